// ===== src/ucb_core.sv
// Purpose: One UART channel: prescaler, baud generator, FIFOs, auto flow control.
// Assumes: mclk is the oscillator clock; rx pin is asynchronous.
// Notes:   Read data appears one cycle after rd_en.
`default_nettype none
// Function
// RULE_01: Prescaler divides the input clock by 1 or 4, chosen by modem_control bit 7.
// RULE_02: Baud generator divides prescaler output by divisor 1..65535 giving the 16x clock.
// RULE_03: Divisor is divisor_high as upper byte and divisor low register as lower byte.
// RULE_04: Software computes divisor as clock over prescale over sixteen times bit rate.
// RULE_05: Transmitter shifts each bit for exactly 16 sampling clock periods.
// RULE_06: Frame is start, data bits, optional parity, then stop bit or bits.
// RULE_07: Data bits go out least significant first.
// RULE_08: With FIFO enabled each transmit_holding write pushes into 128-byte FIFO.
// RULE_09: Non-FIFO mode sets line_status bit 5 on transfer, raising transmit-empty interrupt.
// RULE_10: Line_status bit 6 sets only when shifter and transmit FIFO are empty.
// RULE_11: In FIFO mode line_status bit 5 is set whenever transmit FIFO is empty.
// RULE_12: FIFO mode transmit-empty interrupt when level drops below transmit trigger.
// RULE_13: After falling edge wait 8 sampling clocks; start valid only if still low.
// RULE_14: Every data and stop bit is sampled at its centre by 16x counting.
// RULE_15: Receive FIFO holds 128 entries of 8 data bits plus 3 error tags.
// RULE_16: Reading receive_holding pops FIFO; status bits 2-4 show new head tags.
// RULE_17: Receive-data interrupt per character, or at trigger level in FIFO mode.
// RULE_18: Timeout interrupt when data waits and no character for 4 words plus 12 bits.
// RULE_19: Auto request-to-send enabled by enhanced_feature bit 6, started by modem_control bit 1.
// RULE_20: Auto control deasserts at next higher trigger, reasserts at next lower level.
// RULE_21: While deasserted, receiver keeps accepting characters until FIFO is full.
// RULE_22: Interrupt_status bit 5 and interrupt on auto deassert, when enabled.
// RULE_23: Remote sender pauses while request-to-send is deasserted.
// RULE_24: Line_control bits 0-1 select 5 to 8 bit characters for framing and timeout.
// RULE_25: After reset the prescaler divides by 1.
// RULE_26: Receiver attaches framing, parity and break tags as it stores each character.
module ucb_core #(
	parameter int DEPTH = 128 // FIFO depth, both directions
) (
	input  wire logic       mclk,     // Oscillator clock, 50 MHz
	input  wire logic       reset,    // Asynchronous reset, active high
	input  wire logic [3:0] addr,     // Register index
	input  wire logic       wr_en,    // Register write strobe
	input  wire logic [7:0] wdata,    // Write data
	input  wire logic       rd_en,    // Register read strobe
	output logic      [7:0] rdata,    // Read data, registered
	output logic            irq,      // Interrupt request, active high
	input  wire logic       rx_pin,   // Serial input
	output logic            tx_pin,   // Serial output
	output logic            rts_n     // Request-to-send, active low
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CAP = AW'(0) + (AW+1)'(DEPTH);

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ucb_state_type;

	logic [7:0] ier_reg, lcr_reg, mcr_reg, dll_reg, dlm_reg, efr_reg, fcr_reg, rdata_reg;

	// Register decode
	wire wr_data = wr_en && addr == ucb_pkg::OFS_DATA;
	wire rd_data = rd_en && addr == ucb_pkg::OFS_DATA;
	wire rd_isr  = rd_en && addr == ucb_pkg::OFS_FCR;
	wire rd_lsr  = rd_en && addr == ucb_pkg::OFS_LSR;
	wire wr_fcr  = wr_en && addr == ucb_pkg::OFS_FCR;
	wire fifo_en = fcr_reg[ucb_pkg::FCR_EN];
	wire enh_en  = efr_reg[ucb_pkg::EFR_ENH];
	wire [AW:0] cap = fifo_en ? CAP : (AW+1)'(1);
	wire [7:0] ier_mask = enh_en ? 8'hFF : 8'h0F; // Upper enables locked until enhanced mode

	// Control registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ier_reg <= ucb_pkg::RST_ZERO;
			lcr_reg <= ucb_pkg::RST_ZERO;
			// RULE_25: divide by one
			mcr_reg <= ucb_pkg::RST_ZERO;
			dll_reg <= ucb_pkg::RST_DLL;
			dlm_reg <= ucb_pkg::RST_DLM;
			efr_reg <= ucb_pkg::RST_ZERO;
			fcr_reg <= ucb_pkg::RST_ZERO;
		end else if (wr_en) begin
			unique case (addr)
				ucb_pkg::OFS_IER: ier_reg <= wdata & ier_mask;
				ucb_pkg::OFS_FCR: fcr_reg <= wdata;
				ucb_pkg::OFS_LCR: lcr_reg <= wdata;
				ucb_pkg::OFS_MCR: mcr_reg <= wdata;
				ucb_pkg::OFS_DLL: dll_reg <= wdata;
				ucb_pkg::OFS_DLM: dlm_reg <= wdata;
				ucb_pkg::OFS_EFR: efr_reg <= wdata;
				default: ;
			endcase
		end
	end

	// RULE_01: prescaler select
	logic [1:0] pre_reg;
	wire pre_tick = !mcr_reg[ucb_pkg::MCR_PRE] || pre_reg == 2'(ucb_pkg::PRE_SLOW - 1);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) pre_reg <= 2'h0;
		else pre_reg <= pre_tick ? 2'h0 : pre_reg + 2'h1;
	end

	// RULE_03: divisor bytes
	wire [15:0] divisor = {dlm_reg, dll_reg};
	// RULE_02: baud divider; zero is treated as one
	logic [15:0] brg_reg;
	wire tick = pre_tick && (brg_reg + 16'h1 >= divisor);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) brg_reg <= 16'h0000;
		else if (pre_tick) brg_reg <= tick ? 16'h0000 : brg_reg + 16'h1;
	end

	// Frame shape from line_control
	// RULE_24: character length
	wire [3:0] nbits  = 4'h5 + {2'b00, lcr_reg[1:0]};
	wire       par_en = lcr_reg[ucb_pkg::LCR_PEN];
	function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic ev);
		logic [7:0] m;
		m = 8'hFF >> (4'h8 - n);
		par_of = ^(d & m) ^ !ev;
	endfunction

	// Transmit FIFO
	logic [7:0]  tx_mem [DEPTH];
	logic [AW-1:0] tw_reg, tr_reg;
	logic [AW:0] tc_reg;
	ucb_state_type ts_reg;
	logic [3:0] tt_reg, tb_reg;
	logic [7:0] tsh_reg;
	logic       tbit_reg, tstop_reg;
	wire tx_push = wr_data && tc_reg < cap;   // A write to a full FIFO is dropped
	wire tx_load = ts_reg == ST_IDLE && tc_reg != '0;
	wire tx_rst  = wr_fcr && wdata[ucb_pkg::FCR_TXR];

	// RULE_08: push and pointer advance
	always_ff @(posedge mclk) begin
		if (tx_push) tx_mem[tw_reg] <= wdata;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tw_reg <= '0;
			tr_reg <= '0;
			tc_reg <= '0;
		end else if (tx_rst) begin
			tw_reg <= '0;
			tr_reg <= '0;
			tc_reg <= '0;
		end else begin
			tw_reg <= tx_push ? tw_reg + 1'b1 : tw_reg;
			tr_reg <= tx_load ? tr_reg + 1'b1 : tr_reg;
			tc_reg <= tc_reg + (AW+1)'(tx_push) - (AW+1)'(tx_load);
		end
	end

	// Transmit shifter; each bit holds sixteen ticks
	wire tbit_end = tick && tt_reg == ucb_pkg::FULL_BIT;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ts_reg <= ST_IDLE;
			tt_reg <= 4'h0;
			tb_reg <= 4'h0;
			tsh_reg <= 8'h00;
			tbit_reg <= 1'b1;
			tstop_reg <= 1'b0;
		end else begin
			if (ts_reg != ST_IDLE && tick) tt_reg <= tt_reg + 4'h1;
			unique case (ts_reg)
				ST_IDLE: if (tx_load) begin
					tsh_reg <= tx_mem[tr_reg];
					tt_reg <= 4'h0;
					ts_reg <= ST_START;
					// RULE_06: start bit first
					tbit_reg <= 1'b0;
				end
				ST_START: if (tbit_end) begin
					ts_reg <= ST_DATA;
					tb_reg <= 4'h1;
					// RULE_07: bit 0 leads
					tbit_reg <= tsh_reg[0];
				end
				// RULE_05: sixteen ticks per bit
				ST_DATA: if (tbit_end) begin
					if (tb_reg == nbits) begin
						ts_reg <= par_en ? ST_PAR : ST_STOP;
						tbit_reg <= par_en ? par_of(tsh_reg, nbits, lcr_reg[ucb_pkg::LCR_EPS]) : 1'b1;
						tstop_reg <= lcr_reg[ucb_pkg::LCR_STP];
					end else begin
						tbit_reg <= tsh_reg[tb_reg[2:0]];
						tb_reg <= tb_reg + 4'h1;
					end
				end
				ST_PAR: if (tbit_end) begin
					ts_reg <= ST_STOP;
					tbit_reg <= 1'b1;
				end
				ST_STOP: if (tbit_end) begin
					if (tstop_reg) tstop_reg <= 1'b0;
					else ts_reg <= ST_IDLE;
				end
				default: ts_reg <= ST_IDLE;
			endcase
		end
	end
	assign tx_pin = tbit_reg && !lcr_reg[ucb_pkg::LCR_BRK];

	// Receive pin synchroniser and edge detect
	logic rx_s1, rx_s2, rx_s3;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end
	wire rx_fall = rx_s3 && !rx_s2;

	// Receive shifter
	ucb_state_type rs_reg;
	logic [3:0] rt_reg, rb_reg;
	logic [7:0] rsh_reg;
	logic       rpe_reg, rst2_reg;
	logic       rv_reg;   // One-cycle word valid
	logic [10:0] rw_reg;   // {break, framing, parity, data}
	wire rmid = tick && rt_reg == ucb_pkg::FULL_BIT;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rs_reg <= ST_IDLE;
			rt_reg <= 4'h0;
			rb_reg <= 4'h0;
			rsh_reg <= 8'h00;
			rpe_reg <= 1'b0;
			rst2_reg <= 1'b0;
			rv_reg <= 1'b0;
			rw_reg <= 11'h000;
		end else begin
			rv_reg <= 1'b0;
			if (rs_reg != ST_IDLE && tick) rt_reg <= rt_reg + 4'h1;
			unique case (rs_reg)
				ST_IDLE: if (rx_fall) begin
					rs_reg <= ST_START;
					rt_reg <= 4'h0;
				end
				// RULE_13: validate start at its centre
				ST_START: if (tick && rt_reg == ucb_pkg::HALF_BIT) begin
					rt_reg <= 4'h0;
					rb_reg <= 4'h0;
					rsh_reg <= 8'h00;
					rs_reg <= rx_s2 ? ST_IDLE : ST_DATA;
				end
				// RULE_14: centre sampling
				ST_DATA: if (rmid) begin
					rsh_reg[rb_reg[2:0]] <= rx_s2;
					rb_reg <= rb_reg + 4'h1;
					if (rb_reg + 4'h1 == nbits) rs_reg <= par_en ? ST_PAR : ST_STOP;
				end
				ST_PAR: if (rmid) begin
					rpe_reg <= rx_s2 != par_of(rsh_reg, nbits, lcr_reg[ucb_pkg::LCR_EPS]);
					rst2_reg <= rx_s2;
					rs_reg <= ST_STOP;
				end
				ST_STOP: if (rmid) begin
					rs_reg <= ST_IDLE;
					rv_reg <= 1'b1;
					// RULE_26: tags attached to the word
					rw_reg <= {rsh_reg == 8'h00 && !rx_s2 && !(par_en && rst2_reg),
						!rx_s2, par_en && rpe_reg, rsh_reg};
					rpe_reg <= 1'b0;
					rst2_reg <= 1'b0;
				end
				default: rs_reg <= ST_IDLE;
			endcase
		end
	end

	// Two-entry buffer between shifter and receive FIFO; a word arriving with both entries full is lost
	logic [10:0] sb0_reg, sb1_reg;
	logic [1:0]  sbc_reg;
	logic [AW:0] rc_reg;
	wire sb_in_rdy  = sbc_reg != 2'h2;
	wire sb_out_vld = sbc_reg != 2'h0;
	// RULE_21: accept until full
	wire sb_out_rdy = rc_reg < cap;
	wire sb_push    = rv_reg && sb_in_rdy;
	wire sb_pop     = sb_out_vld && sb_out_rdy;
	wire overrun    = rv_reg && !sb_in_rdy;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sbc_reg <= 2'h0;
			sb0_reg <= 11'h000;
			sb1_reg <= 11'h000;
		end else begin
			sbc_reg <= sbc_reg + 2'(sb_push) - 2'(sb_pop);
			if (sb_pop) sb0_reg <= (sbc_reg == 2'h2) ? sb1_reg : rw_reg;
			else if (sb_push && sbc_reg == 2'h0) sb0_reg <= rw_reg;
			if (sb_push && (sbc_reg == 2'h2 || (sbc_reg == 2'h1 && !sb_pop))) sb1_reg <= rw_reg;
		end
	end

	// RULE_15: 128 by 11 receive FIFO
	logic [10:0] rx_mem [DEPTH];
	logic [AW-1:0] rwp_reg, rrp_reg;
	wire rx_pop = rd_data && rc_reg != '0;
	wire rx_rst = wr_fcr && wdata[ucb_pkg::FCR_RXR];
	always_ff @(posedge mclk) begin
		if (sb_pop) rx_mem[rwp_reg] <= sb0_reg;
	end
	// RULE_16: read advances pointer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rwp_reg <= '0;
			rrp_reg <= '0;
			rc_reg <= '0;
		end else if (rx_rst) begin
			rwp_reg <= '0;
			rrp_reg <= '0;
			rc_reg <= '0;
		end else begin
			rwp_reg <= sb_pop ? rwp_reg + 1'b1 : rwp_reg;
			rrp_reg <= rx_pop ? rrp_reg + 1'b1 : rrp_reg;
			rc_reg <= rc_reg + (AW+1)'(sb_pop) - (AW+1)'(rx_pop);
		end
	end
	wire [10:0] rx_head = rc_reg != '0 ? rx_mem[rrp_reg] : 11'h000;
	wire [7:0]  rlev    = 8'(rc_reg);
	wire [7:0]  tlev    = 8'(tc_reg);
	wire [7:0]  ttrig   = ucb_pkg::tx_trig(fcr_reg[5:4]);

	// RULE_18: timeout of four words plus twelve bits, counted in ticks
	logic [13:0] to_reg;
	logic        tout_reg;
	wire [13:0] to_lim = {(ucb_pkg::TOUT_WORDS * {6'h00, nbits} + ucb_pkg::TOUT_BITS), 4'h0};
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			to_reg <= 14'h0000;
			tout_reg <= 1'b0;
		end else if (sb_pop || rx_pop || rc_reg == '0) begin
			to_reg <= 14'h0000;
			tout_reg <= 1'b0;
		end else if (tick) begin
			to_reg <= (to_reg == to_lim) ? to_reg : to_reg + 14'h1;
			tout_reg <= to_reg + 14'h1 >= to_lim;
		end
	end

	// RULE_20: hysteresis around the programmed trigger
	logic [7:0] rtrig, r_up, r_dn;
	assign rtrig = ucb_pkg::rx_trig(fcr_reg[7:6]);
	assign r_up  = fcr_reg[7:6] == 2'h3 ? ucb_pkg::RTS_TOP : ucb_pkg::rx_trig(fcr_reg[7:6] + 2'h1);
	assign r_dn  = fcr_reg[7:6] == 2'h0 ? ucb_pkg::RTS_BOT : ucb_pkg::rx_trig(fcr_reg[7:6] - 2'h1);
	wire auto_rts = efr_reg[ucb_pkg::EFR_ART];
	logic rts_on_reg, rts_evt_reg, thre_ev_reg, oe_reg;
	wire rts_drop = auto_rts && rts_on_reg && rlev >= r_up;
	wire [5:0] isr_code;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) rts_on_reg <= 1'b1;
		else if (rts_drop) rts_on_reg <= 1'b0;
		else if (rlev <= r_dn) rts_on_reg <= 1'b1;
	end
	// RULE_19: pin follows modem_control bit 1, gated by auto control
	assign rts_n = !(mcr_reg[ucb_pkg::MCR_RTS] && (!auto_rts || rts_on_reg));

	// Sticky events; a new event in the clearing cycle wins
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rts_evt_reg <= 1'b0;
			thre_ev_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			// RULE_22: auto deassert event
			if (rts_drop && mcr_reg[ucb_pkg::MCR_RTS]) rts_evt_reg <= 1'b1;
			else if (rd_isr && isr_code == ucb_pkg::IC_RTS) rts_evt_reg <= 1'b0;
			// RULE_09 RULE_12: last byte out, or level falls below trigger
			if (tx_load && (tc_reg == (AW+1)'(1) || (fifo_en && tlev == ttrig)))
				thre_ev_reg <= 1'b1;
			else if (wr_data || (rd_isr && isr_code == ucb_pkg::IC_THR)) thre_ev_reg <= 1'b0;
			if (overrun) oe_reg <= 1'b1;
			else if (rd_lsr) oe_reg <= 1'b0;
		end
	end

	// Interrupt sources; priority is timeout, receive data, transmit empty, then auto deassert
	// RULE_17: per character or at trigger level
	wire rx_int  = ier_reg[ucb_pkg::IER_RX] && (fifo_en ? rlev >= rtrig : rc_reg != '0);
	wire to_int  = ier_reg[ucb_pkg::IER_RX] && tout_reg;
	// RULE_12: below transmit trigger
	wire thr_int = ier_reg[ucb_pkg::IER_TX] &&
		(fifo_en ? (tlev < ttrig && thre_ev_reg) : thre_ev_reg);
	wire rts_int = ier_reg[ucb_pkg::IER_RTS] && enh_en && rts_evt_reg;
	assign isr_code = to_int ? ucb_pkg::IC_TOUT : rx_int ? ucb_pkg::IC_RXD :
		thr_int ? ucb_pkg::IC_THR : rts_int ? ucb_pkg::IC_RTS : ucb_pkg::IC_NONE;
	assign irq = isr_code != ucb_pkg::IC_NONE;

	// Line status; RULE_11 and RULE_10 for bits 5 and 6
	wire thr_empty = tc_reg == '0;
	wire tx_empty  = thr_empty && ts_reg == ST_IDLE;
	wire [7:0] line_status = {fifo_en && rx_head[10:8] != 3'h0, tx_empty, thr_empty,
		rx_head[10:8], oe_reg, rc_reg != '0};

	// Read data mux, registered
	logic [7:0] rmux;
	always_comb begin
		unique case (addr)
			ucb_pkg::OFS_DATA: rmux = rx_head[7:0];
			ucb_pkg::OFS_IER:  rmux = ier_reg;
			ucb_pkg::OFS_FCR:  rmux = {fifo_en, fifo_en, isr_code};
			ucb_pkg::OFS_LCR:  rmux = lcr_reg;
			ucb_pkg::OFS_MCR:  rmux = mcr_reg;
			// RULE_16: tags of the head
			ucb_pkg::OFS_LSR:  rmux = line_status;
			ucb_pkg::OFS_DLL:  rmux = dll_reg;
			ucb_pkg::OFS_DLM:  rmux = dlm_reg;
			ucb_pkg::OFS_EFR:  rmux = efr_reg;
			default:           rmux = 8'h00;
		endcase
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) rdata_reg <= 8'h00;
		else if (rd_en) rdata_reg <= rmux;
	end
	assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== src/ucb_pkg.sv
// Purpose: Constants shared by the UART channel core.
// Assumes: One channel, registers on a small parallel port.
// Notes:   Offsets are word indices on a 4-bit address.
`default_nettype none
package ucb_pkg;
	// Register offsets
	localparam logic [3:0] OFS_DATA = 4'h0; // transmit_holding / receive_holding
	localparam logic [3:0] OFS_IER  = 4'h1;
	localparam logic [3:0] OFS_FCR  = 4'h2; // write fifo_control, read interrupt_status
	localparam logic [3:0] OFS_LCR  = 4'h3;
	localparam logic [3:0] OFS_MCR  = 4'h4;
	localparam logic [3:0] OFS_LSR  = 4'h5;
	localparam logic [3:0] OFS_DLL  = 4'h6;
	localparam logic [3:0] OFS_DLM  = 4'h7;
	localparam logic [3:0] OFS_EFR  = 4'h8;
	// Reset values
	localparam logic [7:0] RST_DLL  = 8'h01;
	localparam logic [7:0] RST_DLM  = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Field positions
	localparam int MCR_RTS = 1;
	localparam int MCR_PRE = 7;
	localparam int EFR_ENH = 4;
	localparam int EFR_ART = 6;
	localparam int IER_RX  = 0;
	localparam int IER_TX  = 1;
	localparam int IER_RTS = 6;
	localparam int FCR_EN  = 0;
	localparam int FCR_RXR = 1;
	localparam int FCR_TXR = 2;
	localparam int LCR_STP = 2;
	localparam int LCR_PEN = 3;
	localparam int LCR_EPS = 4;
	localparam int LCR_BRK = 6;
	// Interrupt codes
	localparam logic [5:0] IC_NONE = 6'h01;
	localparam logic [5:0] IC_TOUT = 6'h0C;
	localparam logic [5:0] IC_RXD  = 6'h04;
	localparam logic [5:0] IC_THR  = 6'h02;
	localparam logic [5:0] IC_RTS  = 6'h20;
	// Timing
	localparam int          PRE_SLOW   = 4;
	localparam logic [3:0]  HALF_BIT   = 4'h7;
	localparam logic [3:0]  FULL_BIT   = 4'hF;
	localparam logic [9:0]  TOUT_WORDS = 10'h004;
	localparam logic [9:0]  TOUT_BITS  = 10'h00C;
	// Receive trigger table and transmit trigger table
	function automatic logic [7:0] rx_trig(input logic [1:0] s);
		case (s)
			2'h0: rx_trig = 8'h08;
			2'h1: rx_trig = 8'h10;
			2'h2: rx_trig = 8'h38;
			default: rx_trig = 8'h3C;
		endcase
	endfunction
	function automatic logic [7:0] tx_trig(input logic [1:0] s);
		case (s)
			2'h0: tx_trig = 8'h08;
			2'h1: tx_trig = 8'h10;
			2'h2: tx_trig = 8'h20;
			default: tx_trig = 8'h38;
		endcase
	endfunction
	localparam logic [7:0] RTS_TOP = 8'h78;
	localparam logic [7:0] RTS_BOT = 8'h04;
endpackage
`default_nettype wire

// ===== verif/ucb_core_sva.sv
// Purpose: Port-level checks for the UART channel core.
// Assumes: A register write takes effect one cycle after its strobe.
// Notes:   Shadows of a few registers are rebuilt from the writes.
`default_nettype none
module ucb_core_sva #(
	parameter int DEPTH = 128 // FIFO depth, kept for the bind
) (
	input wire logic       mclk,   // Clock
	input wire logic       reset,  // Asynchronous reset
	input wire logic [3:0] addr,   // Register index
	input wire logic       wr_en,  // Write strobe
	input wire logic [7:0] wdata,  // Write data
	input wire logic       rd_en,  // Read strobe
	input wire logic [7:0] rdata,  // Read data
	input wire logic       irq,    // Interrupt request
	input wire logic       rx_pin, // Serial input
	input wire logic       tx_pin, // Serial output
	input wire logic       rts_n   // Request-to-send, active low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dll_sh;
	logic [7:0] dlm_sh;
	logic [7:0] mcr_sh;
	logic [7:0] efr_sh;
	logic [7:0] ier_sh;
	logic       fen_sh;
	int         low_run;
	logic       fast;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Only divisor 0 or 1 at prescale 1 makes every clock a tick, so bit edges are exact
	assign fast = ({dlm_sh, dll_sh} <= 16'h0001) && !mcr_sh[ucb_pkg::MCR_PRE];
	// Shadows follow writes; upper enable bits need the enhanced bit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dll_sh <= ucb_pkg::RST_DLL;
			dlm_sh <= ucb_pkg::RST_DLM;
			mcr_sh <= 8'h00;
			efr_sh <= 8'h00;
			ier_sh <= 8'h00;
			fen_sh <= 1'b0;
		end else if (wr_en) begin
			if (addr == ucb_pkg::OFS_DLL) dll_sh <= wdata;
			if (addr == ucb_pkg::OFS_DLM) dlm_sh <= wdata;
			if (addr == ucb_pkg::OFS_MCR) mcr_sh <= wdata;
			if (addr == ucb_pkg::OFS_EFR) efr_sh <= wdata;
			if (addr == ucb_pkg::OFS_FCR) fen_sh <= wdata[ucb_pkg::FCR_EN];
			if (addr == ucb_pkg::OFS_IER)
				ier_sh <= efr_sh[ucb_pkg::EFR_ENH] ? wdata : {4'h0, wdata[3:0]};
		end
	end
	// Length of the current low run on the serial output
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) low_run <= 0;
		else if (!tx_pin) low_run <= low_run + 1;
		else low_run <= 0;
	end
	tx_bit_len_a: assert property ($rose(tx_pin) && fast |-> low_run % 16 == 0)
		else $error("low run on tx is not whole bits");
	div_low_a: assert property (rd_en && addr == ucb_pkg::OFS_DLL |=> rdata == $past(dll_sh))
		else $error("low divisor readback wrong");
	div_high_a: assert property (rd_en && addr == ucb_pkg::OFS_DLM |=> rdata == $past(dlm_sh))
		else $error("high divisor readback wrong");
	pre_sel_a: assert property (rd_en && addr == ucb_pkg::OFS_MCR |=> rdata[7] == $past(mcr_sh[7]))
		else $error("prescale select readback wrong");
	rts_manual_a: assert property (!efr_sh[ucb_pkg::EFR_ART] |-> rts_n == !mcr_sh[ucb_pkg::MCR_RTS])
		else $error("rts output not following modem control");
	irq_quiet_a: assert property (ier_sh == 8'h00 |-> !irq)
		else $error("interrupt with all sources disabled");
	ier_mask_a: assert property (rd_en && addr == ucb_pkg::OFS_IER |=> rdata == $past(ier_sh))
		else $error("interrupt enable readback wrong");
	isr_mode_a: assert property (rd_en && addr == ucb_pkg::OFS_FCR |=> rdata[7:6] == {2{$past(fen_sh)}})
		else $error("fifo mode bits in status wrong");
	tx_empty_a: assert property (rd_en && addr == ucb_pkg::OFS_LSR ##1 rdata[6] |-> tx_pin)
		else $error("transmitter empty while line is low");
	c_rts_off: cover property (efr_sh[ucb_pkg::EFR_ART] && $rose(rts_n));
	c_irq: cover property ($rose(irq));
	c_slow: cover property ($rose(tx_pin) && mcr_sh[ucb_pkg::MCR_PRE]);
endmodule
bind ucb_core ucb_core_sva #(.DEPTH(DEPTH)) sva_i (.mclk(mclk), .reset(reset), .addr(addr),
	.wr_en(wr_en), .wdata(wdata), .rd_en(rd_en), .rdata(rdata), .irq(irq), .rx_pin(rx_pin),
	.tx_pin(tx_pin), .rts_n(rts_n));
`default_nettype wire

// ===== verif/ucb_core_tb_top.sv
// Purpose: Self-checking bench for the UART channel core.
// Assumes: Divisor 1 at prescale 1 gives 16 clocks per bit.
// Notes:   Inputs change on the falling clock edge.
`default_nettype none
module ucb_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk;
	logic       reset;
	logic [3:0] addr;
	logic       wr_en;
	logic [7:0] wdata;
	logic       rd_en;
	logic [7:0] rdata;
	logic       irq;
	logic       rx_pin;
	logic       tx_pin;
	logic       rts_n;
	int         mismatches;
	int         checked;
	logic [7:0] v;
	int         i;
	ucb_core uut (.mclk(mclk), .reset(reset), .addr(addr), .wr_en(wr_en), .wdata(wdata),
		.rd_en(rd_en), .rdata(rdata), .irq(irq), .rx_pin(rx_pin), .tx_pin(tx_pin), .rts_n(rts_n));
	ucb_remote m (.mclk(mclk), .tx_in(tx_pin), .rts_n(rts_n), .line(rx_pin));
	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic test_done();
		if (mismatches == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge mclk);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge mclk);
		addr = a;
		rd_en = 1'b1;
		@(negedge mclk);
		rd_en = 1'b0;
		d = rdata;
	endtask
	// Bounded wait for the remote to finish decoding frame n
	task automatic wait_frame(input int n);
		for (int k = 0; k < 8000 && m.got_n < n; k++) @(posedge mclk);
		chk(8'(m.got_n), 8'(n));
	endtask
	task automatic t_reset();
		rd(ucb_pkg::OFS_DLL, v);
		chk(v, 8'h01);
		rd(ucb_pkg::OFS_DLM, v);
		chk(v, 8'h00);
		rd(ucb_pkg::OFS_MCR, v);
		chk(v, 8'h00);
		rd(ucb_pkg::OFS_LSR, v);
		chk(v, 8'h60);
		rd(4'hF, v);
		chk(v, 8'h00);
		chk({7'h0, rts_n}, 8'h01);
	endtask
	// Every character length, then even parity
	task automatic t_tx();
		for (i = 0; i < 5; i++) begin
			m.nbits = (i < 4) ? 5 + i : 8;
			m.par_en = (i == 4);
			wr(ucb_pkg::OFS_LCR, (i < 4) ? 8'(i) : 8'h1B);
			wr(ucb_pkg::OFS_DATA, 8'hA5);
			rd(ucb_pkg::OFS_LSR, v);
			chk(v & 8'h40, 8'h00);
			wait_frame(i + 1);
			chk(m.got_d, 8'hA5 & (8'hFF >> (8 - m.nbits)));
			chk({6'h0, m.got_p, m.got_stop}, 8'h01);
		end
		m.par_en = 1'b0;
		wr(ucb_pkg::OFS_LCR, 8'h03);
	endtask
	task automatic t_rate();
		m.bit_cyc = 64;
		wr(ucb_pkg::OFS_MCR, 8'h80);
		wr(ucb_pkg::OFS_DATA, 8'h3C);
		wait_frame(6);
		chk(m.got_d, 8'h3C);
		wr(ucb_pkg::OFS_MCR, 8'h00);
		m.bit_cyc = 32;
		// 32 clocks per bit over 16 samples gives divisor 2
		wr(ucb_pkg::OFS_DLL, 8'h02);
		wr(ucb_pkg::OFS_DATA, 8'hC3);
		wait_frame(7);
		chk(m.got_d, 8'hC3);
		wr(ucb_pkg::OFS_DLL, 8'h01);
		m.bit_cyc = 16;
	endtask
	// False start, then a framing error tag and the pop that clears it
	task automatic t_rx();
		wr(ucb_pkg::OFS_FCR, 8'h01);
		m.glitch();
		repeat (40) @(negedge mclk);
		rd(ucb_pkg::OFS_LSR, v);
		chk(v & 8'h01, 8'h00);
		m.send(8'hC3, 1'b1);
		m.send(8'h5A, 1'b0);
		repeat (8) @(negedge mclk);
		rd(ucb_pkg::OFS_LSR, v);
		chk(v, 8'hE9);
		rd(ucb_pkg::OFS_DATA, v);
		chk(v, 8'hC3);
		rd(ucb_pkg::OFS_LSR, v);
		chk(v, 8'h61);
		rd(ucb_pkg::OFS_DATA, v);
		chk(v, 8'h5A);
	endtask
	task automatic t_thr();
		wr(ucb_pkg::OFS_FCR, 8'h00);
		wr(ucb_pkg::OFS_IER, 8'h02);
		wr(ucb_pkg::OFS_DATA, 8'h96);
		repeat (4) @(negedge mclk);
		chk({7'h0, irq}, 8'h01);
		rd(ucb_pkg::OFS_FCR, v);
		chk(v, 8'h02);
		chk({7'h0, irq}, 8'h00);
		wait_frame(8);
		wr(ucb_pkg::OFS_IER, 8'h00);
	endtask
	// One byte below the trigger waits for the timeout
	task automatic t_tout();
		wr(ucb_pkg::OFS_FCR, 8'h01);
		wr(ucb_pkg::OFS_IER, 8'h01);
		m.send(8'h7E, 1'b0);
		repeat (560) @(negedge mclk);
		chk({7'h0, irq}, 8'h00);
		repeat (400) @(negedge mclk);
		rd(ucb_pkg::OFS_FCR, v);
		chk(v, 8'hCC);
		rd(ucb_pkg::OFS_DATA, v);
		chk(v, 8'h7E);
		wr(ucb_pkg::OFS_IER, 8'h00);
	endtask
	// Trigger 8: off at 16, back on at 4, remote held meanwhile
	task automatic t_rts();
		wr(ucb_pkg::OFS_EFR, 8'h50);
		wr(ucb_pkg::OFS_IER, 8'h40);
		wr(ucb_pkg::OFS_MCR, 8'h02);
		m.flow = 1'b1;
		for (i = 0; i < 16; i++) begin
			chk({7'h0, rts_n}, 8'h00);
			m.send(8'(i), 1'b0);
		end
		chk({7'h0, rts_n}, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(ucb_pkg::OFS_FCR, v);
		chk(v, 8'hE0);
		fork
			m.send(8'hAA, 1'b0);
		join_none
		for (i = 0; i < 16; i++) begin
			// The pin answers one clock after the pop that reaches the low level
			if (i == 12) @(negedge mclk);
			if (i == 11 || i == 12) chk({7'h0, rts_n}, (i == 12) ? 8'h00 : 8'h01);
			rd(ucb_pkg::OFS_DATA, v);
			chk(v, 8'(i));
		end
		repeat (300) @(negedge mclk);
		rd(ucb_pkg::OFS_DATA, v);
		chk(v, 8'hAA);
	endtask
	initial begin
		reset = 1'b1;
		addr = 4'h0;
		wr_en = 1'b0;
		wdata = 8'h00;
		rd_en = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		t_reset();
		t_tx();
		t_rate();
		t_rx();
		t_thr();
		t_tout();
		t_rts();
		test_done();
	end
	// The whole run needs well under a quarter of this span
	initial begin
		#1000000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire

// ===== verif/ucb_remote.sv
// Purpose: Remote serial device facing the channel.
// Assumes: The bench changes its settings only between frames.
// Notes:   The line idles high, as a pulled-up UART line does.
`default_nettype none
module ucb_remote (
	input  wire logic mclk,  // Bench clock
	input  wire logic tx_in, // Channel serial output
	input  wire logic rts_n, // Channel request-to-send, active low
	output var logic  line   // Serial line into the channel
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bit_cyc = 16; // Clocks per bit
	int         nbits   = 8;
	logic       par_en  = 1'b0;
	logic       flow    = 1'b0;
	int         got_n   = 0;
	logic [7:0] got_d;
	logic       got_p;
	logic       got_stop;
	int         k;
	initial line = 1'b1;
	always begin
		@(negedge tx_in);
		got_d = 8'h00;
		got_p = 1'b0;
		repeat (bit_cyc / 2) @(posedge mclk);
		for (k = 0; k <= nbits + int'(par_en); k++) begin
			repeat (bit_cyc) @(posedge mclk);
			if (k < nbits) got_d[k] = tx_in;
			else if (k == nbits && par_en) got_p = tx_in;
			got_stop = tx_in;
		end
		got_n++;
	end
	task automatic send(input logic [7:0] d, input logic bad_stop);
		int j;
		@(negedge mclk);
		while (flow && rts_n) @(negedge mclk);
		line = 1'b0;
		repeat (bit_cyc) @(negedge mclk);
		for (j = 0; j < nbits; j++) begin
			line = d[j];
			repeat (bit_cyc) @(negedge mclk);
		end
		line = ~bad_stop;
		repeat (bit_cyc) @(negedge mclk);
		// One idle bit, so a bad stop still leaves an edge for the next start
		line = 1'b1;
		repeat (bit_cyc) @(negedge mclk);
	endtask
	// Low pulse well under half a bit
	task automatic glitch();
		@(negedge mclk);
		line = 1'b0;
		repeat (4) @(negedge mclk);
		line = 1'b1;
	endtask
endmodule
`default_nettype wire
